// File: rtl/uifl_pkg.sv
// shared constants and types for the interrupt id / line format block
package uifl_pkg;
    // register offsets on the parallel bus (3-bit address)
    localparam logic [2:0] UIFL_OFS_IID = 3'h2;
    localparam logic [2:0] UIFL_OFS_LFC = 3'h3;
    localparam logic [2:0] UIFL_OFS_TXD = 3'h0;
    // line format control field positions
    localparam int UIFL_LFC_DLAB = 7;
    localparam int UIFL_LFC_BRK = 6;
    localparam int UIFL_LFC_PSEL_HI = 5;
    localparam int UIFL_LFC_PSEL_LO = 4;
    localparam int UIFL_LFC_PEN = 3;
    localparam int UIFL_LFC_STOP = 2;
    localparam int UIFL_LFC_WLEN_HI = 1;
    localparam logic [7:0] UIFL_LFC_RST = 8'h00;
    // interrupt identification codes, bits 5:0
    localparam logic [5:0] UIFL_ID_LINE = 6'h06;
    localparam logic [5:0] UIFL_ID_RXDATA = 6'h04;
    localparam logic [5:0] UIFL_ID_RXTMO = 6'h0C;
    localparam logic [5:0] UIFL_ID_TXEMPTY = 6'h02;
    localparam logic [5:0] UIFL_ID_MODEM = 6'h00;
    localparam logic [5:0] UIFL_ID_XOFF = 6'h10;
    localparam logic [5:0] UIFL_ID_FLOW = 6'h20;
    localparam logic [5:0] UIFL_ID_NONE = 6'h01;
    localparam logic [1:0] UIFL_FIFO_ON = 2'h3;
    // data fifo shape
    localparam int UIFL_FIFO_W = 8;
    localparam int UIFL_FIFO_D = 16;
    // serial timing: half-bit ticks, stop counts in half bits
    localparam int UIFL_CLK_HZ = 40000000;
    localparam int UIFL_BAUD = 115200;
    localparam int UIFL_HALF_CYC = UIFL_CLK_HZ / (2 * UIFL_BAUD);
    localparam logic [3:0] UIFL_STOP_ONE = 4'h2;
    localparam logic [3:0] UIFL_STOP_ONEHALF = 4'h3;
    localparam logic [3:0] UIFL_STOP_TWO = 4'h4;
    localparam logic [3:0] UIFL_WLEN_BASE = 4'h5;
    // transmitter states
    typedef enum logic [2:0] {
        UIFL_TX_IDLE, UIFL_TX_START, UIFL_TX_DATA, UIFL_TX_PAR, UIFL_TX_STOP
    } uifl_txst_t;
endpackage : uifl_pkg

// File: rtl/uifl_fifo.sv
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ps
module uifl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_empty
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } uifl_fifo_st_t;
    uifl_fifo_st_t s_q, s_d;
    logic push, pop;

    // handshakes straight from the count
    assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.cnt != '0);
    assign o_empty = (s_q.cnt == '0);
    assign o_out_data = s_q.mem[s_q.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // pointer wrap assumes power-of-two depth
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = i_in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush) begin
            s_d.wp = '0;
            s_d.rp = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : uifl_fifo

// File: rtl/uifl_top.sv
// interrupt identification, line format control and framed transmitter
`timescale 1ns/1ps
module uifl_top
    import uifl_pkg::*;
#(
    parameter int HALF_CYC = uifl_pkg::UIFL_HALF_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // parallel host bus
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_wr_ready,
    // interrupt sources, xon clear and mode enables from the rest of the uart
    input wire logic i_line_status_err,
    input wire logic i_rx_data_avail,
    input wire logic i_rx_timeout,
    input wire logic i_modem_change,
    input wire logic i_xoff_detect,
    input wire logic i_xon_detect,
    input wire logic i_special_char,
    input wire logic i_flow_change,
    input wire logic i_fifo_enable,
    input wire logic i_enh_enable,
    // format settings used by the receiver
    output logic o_divisor_access,
    output logic [3:0] o_word_bits,
    output logic o_parity_en,
    output logic [1:0] o_parity_sel,
    output logic o_stop_long,
    // serial side
    output logic o_tx,
    output logic o_irq
);
    typedef struct packed {
        logic [7:0] lfc;
        logic [7:0] rdata;
        logic txe_pend;
        logic xoff_q;
        logic flow_q;
        uifl_txst_t st;
        logic [15:0] tick;
        logic half;
        logic [7:0] shreg;
        logic [3:0] bitn;
        logic par;
        logic [3:0] stopn;
        logic tx;
    } uifl_st_t;
    uifl_st_t s_q, s_d;

    logic rd_iid, wr_lfc, wr_txd;
    logic [5:0] id_code;
    logic pend;
    logic f_valid, f_ready, f_empty, f_in_ready;
    logic [7:0] f_data;
    logic tick_en;

    // word length code to bit count
    function automatic logic [3:0] wlen(input logic [1:0] code);
        wlen = UIFL_WLEN_BASE + {2'b00, code};
    endfunction : wlen

    // parity bit for the selected mode
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [1:0] sel,
                                    input logic [3:0] nb);
        logic [7:0] m;
        logic x;
        m = d & ((8'h01 << nb) - 8'h01);
        x = ^m;
        unique case (sel)
            2'b00: par_of = ~x;
            2'b01: par_of = x;
            2'b10: par_of = 1'b1;
            2'b11: par_of = 1'b0;
        endcase
    endfunction : par_of

    // host decode; reads of the id register work in any access mode
    assign rd_iid = i_rd && (i_addr == UIFL_OFS_IID);
    assign wr_lfc = i_wr && (i_addr == UIFL_OFS_LFC);
    // data writes go to the divisor while bit 7 is set, so not queued
    assign wr_txd = i_wr && (i_addr == UIFL_OFS_TXD)
                    && !s_q.lfc[UIFL_LFC_DLAB];
    assign o_wr_ready = f_in_ready;

    // the holding fifo in front of the transmitter
    uifl_fifo #(
        .WIDTH(UIFL_FIFO_W),
        .DEPTH(UIFL_FIFO_D)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_flush(1'b0),
        .i_in_valid(wr_txd),
        .o_in_ready(f_in_ready),
        .i_in_data(i_wdata),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready),
        .o_out_data(f_data),
        .o_empty(f_empty)
    );
    // transmitter only pulls a word while idle and not in break
    assign f_ready = (s_q.st == UIFL_TX_IDLE) && !s_q.lfc[UIFL_LFC_BRK];

    // priority encoder: first true source wins, others stay hidden
    always_comb begin
        pend = 1'b1;
        if (i_line_status_err) begin
            id_code = UIFL_ID_LINE;
        end else if (i_rx_timeout) begin
            id_code = UIFL_ID_RXTMO;
        end else if (i_rx_data_avail) begin
            id_code = UIFL_ID_RXDATA;
        end else if (s_q.txe_pend) begin
            id_code = UIFL_ID_TXEMPTY;
        end else if (i_modem_change) begin
            id_code = UIFL_ID_MODEM;
        end else if (i_enh_enable && s_q.xoff_q) begin
            id_code = UIFL_ID_XOFF;
        end else if (i_enh_enable && s_q.flow_q) begin
            id_code = UIFL_ID_FLOW;
        end else begin
            id_code = UIFL_ID_NONE;
            pend = 1'b0;
        end
    end

    // half-bit tick divider enable
    assign tick_en = (s_q.tick == 16'(HALF_CYC - 1));

    // next-state logic for registers, flags and transmitter
    always_comb begin
        s_d = s_q;
        if (wr_lfc) begin
            s_d.lfc = i_wdata;
        end
        if (rd_iid) begin
            s_d.rdata = {(i_fifo_enable ? UIFL_FIFO_ON : 2'b00),
                         id_code};
        end else if (i_rd && i_addr == UIFL_OFS_LFC) begin
            s_d.rdata = s_q.lfc;
        end else if (i_rd) begin
            s_d.rdata = 8'h00;
        end
        // tx-empty clears on id read showing it, or new data; set wins
        if ((rd_iid && id_code == UIFL_ID_TXEMPTY) || wr_txd) begin
            s_d.txe_pend = 1'b0;
        end
        if (f_empty && s_q.st == UIFL_TX_IDLE && !s_q.txe_pend && !wr_txd
            && s_q.tx) begin
            s_d.txe_pend = 1'b0;
        end
        // sticky xoff flag held until xon; set wins over clear
        if (i_xon_detect) begin
            s_d.xoff_q = 1'b0;
        end
        if (i_xoff_detect || i_special_char) begin
            s_d.xoff_q = 1'b1;
        end
        // flow flag cleared when read out
        if (rd_iid && id_code == UIFL_ID_FLOW) begin
            s_d.flow_q = 1'b0;
        end
        if (i_flow_change) begin
            s_d.flow_q = 1'b1;
        end
        s_d.tick = tick_en ? 16'h0000 : s_q.tick + 16'h0001;
        if (tick_en) begin
            s_d.half = ~s_q.half;
        end
        unique case (s_q.st)
            UIFL_TX_IDLE: begin
                s_d.tx = 1'b1;
                s_d.half = 1'b0;
                if (f_valid && f_ready) begin
                    s_d.shreg = f_data;
                    s_d.par = par_of(f_data, s_q.lfc[UIFL_LFC_PSEL_HI:
                                     UIFL_LFC_PSEL_LO], wlen(
                                     s_q.lfc[UIFL_LFC_WLEN_HI:0]));
                    s_d.bitn = wlen(s_q.lfc[UIFL_LFC_WLEN_HI:0]);
                    s_d.st = UIFL_TX_START;
                    s_d.tx = 1'b0;
                    s_d.tick = 16'h0000;
                end
            end
            UIFL_TX_START: begin
                if (tick_en && s_q.half) begin
                    s_d.st = UIFL_TX_DATA;
                    s_d.tx = s_q.shreg[0];
                end
            end
            UIFL_TX_DATA: begin
                if (tick_en && s_q.half) begin
                    s_d.shreg = {1'b0, s_q.shreg[7:1]};
                    s_d.bitn = s_q.bitn - 4'h1;
                    s_d.tx = s_q.shreg[1];
                    if (s_q.bitn == 4'h1) begin
                        if (s_q.lfc[UIFL_LFC_PEN]) begin
                            s_d.st = UIFL_TX_PAR;
                            s_d.tx = s_q.par;
                        end else begin
                            s_d.st = UIFL_TX_STOP;
                            s_d.tx = 1'b1;
                        end
                        s_d.stopn = !s_q.lfc[UIFL_LFC_STOP] ? UIFL_STOP_ONE
                            : (s_q.lfc[UIFL_LFC_WLEN_HI:0] == 2'b00)
                            ? UIFL_STOP_ONEHALF : UIFL_STOP_TWO;
                    end
                end
            end
            UIFL_TX_PAR: begin
                if (tick_en && s_q.half) begin
                    s_d.st = UIFL_TX_STOP;
                    s_d.tx = 1'b1;
                end
            end
            UIFL_TX_STOP: begin
                // stop counted in half bits so 1.5 fits
                if (tick_en) begin
                    s_d.stopn = s_q.stopn - 4'h1;
                    if (s_q.stopn == 4'h1) begin
                        s_d.st = UIFL_TX_IDLE;
                        if (!f_valid) begin
                            s_d.txe_pend = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.lfc <= UIFL_LFC_RST;
            s_q.rdata <= {2'b00, UIFL_ID_NONE};
            s_q.tx <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; break overrides the line
    assign o_tx = s_q.tx && !s_q.lfc[UIFL_LFC_BRK];
    assign o_irq = pend;
    assign o_rdata = s_q.rdata;
    assign o_divisor_access = s_q.lfc[UIFL_LFC_DLAB];
    assign o_word_bits = wlen(s_q.lfc[UIFL_LFC_WLEN_HI:0]);
    assign o_parity_en = s_q.lfc[UIFL_LFC_PEN];
    assign o_parity_sel = s_q.lfc[UIFL_LFC_PSEL_HI:UIFL_LFC_PSEL_LO];
    assign o_stop_long = s_q.lfc[UIFL_LFC_STOP];
endmodule : uifl_top

// File: sim/uifl_sva.sv
// concurrent checks on the interrupt id / line format block ports
`timescale 1ns/1ps
module uifl_sva
    import uifl_pkg::*;
#(
    parameter int HALF_CYC = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_line_status_err,
    input wire logic i_fifo_enable,
    input wire logic o_divisor_access,
    input wire logic [3:0] o_word_bits,
    input wire logic o_parity_en,
    input wire logic [1:0] o_parity_sel,
    input wire logic o_stop_long,
    input wire logic o_tx,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // decoded host accesses
    wire id_rd = i_rd && i_addr == UIFL_OFS_IID;
    wire fmt_wr = i_wr && i_addr == UIFL_OFS_LFC;
    irq_line_a: assert property (
        i_line_status_err |-> o_irq)
        else $error("irq low with line error pending");
    line_code_a: assert property (
        id_rd && i_line_status_err |=> o_rdata[5:0] == UIFL_ID_LINE)
        else $error("line error code not on top");
    fifo_bits_a: assert property (
        id_rd |=> o_rdata[7:6] == {2{$past(i_fifo_enable)}})
        else $error("fifo mode bits wrong");
    none_flag_a: assert property (
        id_rd |=> o_rdata[0] == !$past(o_irq))
        else $error("pending flag disagrees with irq");
    brk_low_a: assert property (
        fmt_wr && i_wdata[6] ##1 !fmt_wr |=> !o_tx)
        else $error("break not driving line low");
    wlen_a: assert property (
        fmt_wr |=> o_word_bits == 4'h5 + $past(i_wdata[1:0]))
        else $error("word length wrong");
    parity_a: assert property (
        fmt_wr |=> o_parity_en == $past(i_wdata[3])
            && o_parity_sel == $past(i_wdata[5:4]))
        else $error("parity fields wrong");
    div_stop_a: assert property (
        fmt_wr |=> o_divisor_access == $past(i_wdata[7])
            && o_stop_long == $past(i_wdata[2]))
        else $error("divisor or stop field wrong");
    fmt_rst_a: assert property (
        $fell(i_rst) |-> o_word_bits == 4'h5 && !o_parity_en
            && !o_stop_long && !o_divisor_access)
        else $error("format fields not cleared by reset");
    cover property (id_rd && o_irq);
    cover property (fmt_wr && i_wdata[6]);
    cover property (!o_tx ##1 o_tx);
endmodule : uifl_sva

bind uifl_top uifl_sva #(.HALF_CYC(HALF_CYC)) uifl_sva_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_rd(i_rd),
    .i_wr(i_wr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_line_status_err(i_line_status_err),
    .i_fifo_enable(i_fifo_enable),
    .o_divisor_access(o_divisor_access),
    .o_word_bits(o_word_bits),
    .o_parity_en(o_parity_en),
    .o_parity_sel(o_parity_sel),
    .o_stop_long(o_stop_long),
    .o_tx(o_tx),
    .o_irq(o_irq)
);

// File: sim/uifl_rx_model.sv
// remote serial receiver that decodes frames off the transmit line
`timescale 1ns/1ps
module uifl_rx_model #(
    parameter int HALF = 2
) (
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic [3:0] i_bits,
    input wire logic i_par_en,
    output logic [7:0] o_data,
    output logic o_par,
    output logic o_stop,
    output logic o_done
);
    // samples mid-bit on falling edges, clear of the launching edge
    initial begin
        o_data = 8'h00;
        o_par = 1'b0;
        o_stop = 1'b0;
        o_done = 1'b0;
        forever begin
            @(negedge i_line);
            repeat (HALF) @(negedge i_clk);
            o_data = 8'h00;
            for (int i = 0; i < i_bits; i++) begin
                repeat (2 * HALF) @(negedge i_clk);
                o_data[i] = i_line;
            end
            if (i_par_en) begin
                repeat (2 * HALF) @(negedge i_clk);
                o_par = i_line;
            end
            repeat (2 * HALF) @(negedge i_clk);
            o_stop = i_line;
            o_done = 1'b1;
            @(negedge i_clk);
            o_done = 1'b0;
        end
    end
endmodule : uifl_rx_model

// File: sim/tb_uifl_top.sv
// self-checking bench for the interrupt id / line format block
`timescale 1ns/1ps
module tb_uifl_top;
    import uifl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    // 0 line,1 rxdata,2 tmo,3 modem,4 xoff,5 xon,6 spec,7 flow,8 fifo,9 enh
    logic [9:0] src = 10'h000;
    logic [7:0] rdata, rx_data;
    logic wr_ready, tx, irq, rx_par, rx_stop, rx_done, got;
    logic [3:0] m_bits = 4'h8;
    logic m_par = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    uifl_top #(.HALF_CYC(2)) uifl_top_inst (
        .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_rd(rd),
        .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
        .o_wr_ready(wr_ready), .i_line_status_err(src[0]),
        .i_rx_data_avail(src[1]), .i_rx_timeout(src[2]),
        .i_modem_change(src[3]), .i_xoff_detect(src[4]),
        .i_xon_detect(src[5]), .i_special_char(src[6]),
        .i_flow_change(src[7]), .i_fifo_enable(src[8]),
        .i_enh_enable(src[9]), .o_divisor_access(), .o_word_bits(),
        .o_parity_en(), .o_parity_sel(), .o_stop_long(),
        .o_tx(tx), .o_irq(irq));
    uifl_rx_model #(.HALF(2)) uifl_rx_model_inst (
        .i_clk(clk), .i_line(tx), .i_bits(m_bits), .i_par_en(m_par),
        .o_data(rx_data), .o_par(rx_par), .o_stop(rx_stop),
        .o_done(rx_done));
    initial forever #12.5 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // hang guard, generous against roughly 2400 cycles of tests
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    // read data lands on the same edge that takes the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
    endtask : rd_chk
    task automatic wait_rx(output logic f);
        f = 1'b0;
        for (int n = 0; n < 300 && !f; n++) begin
            @(posedge clk);
            f = (rx_done === 1'b1);
        end
    endtask : wait_rx
    task automatic t_reset();
        rd_chk(UIFL_OFS_IID, 8'h01);
        rd_chk(UIFL_OFS_LFC, 8'h00);
        rd_chk(3'h5, 8'h00);
        chk({7'h00, tx}, 8'h01);
    endtask : t_reset
    // flow sources stay silent while the enhanced enable is off
    task automatic t_enh_off();
        src = 10'h090;
        @(negedge clk);
        src = 10'h000;
        rd_chk(UIFL_OFS_IID, 8'h01);
        chk({7'h00, irq}, 8'h00);
    endtask : t_enh_off
    // every source but tx-empty pending; peel them off one at a time
    task automatic t_prio();
        src = 10'h3CF;
        @(negedge clk);
        src = 10'h30F;
        rd_chk(UIFL_OFS_IID, 8'hC6);
        chk({7'h00, irq}, 8'h01);
        src[0] = 1'b0;
        rd_chk(UIFL_OFS_IID, 8'hCC);
        src[2] = 1'b0;
        rd_chk(UIFL_OFS_IID, 8'hC4);
        src[1] = 1'b0;
        rd_chk(UIFL_OFS_IID, 8'hC0);
        rd_chk(UIFL_OFS_IID, 8'hC0);
        src[3] = 1'b0;
        rd_chk(UIFL_OFS_IID, 8'hD0);
        rd_chk(UIFL_OFS_IID, 8'hD0);
        src[5] = 1'b1;
        @(negedge clk);
        src[5] = 1'b0;
        rd_chk(UIFL_OFS_IID, 8'hE0);
        rd_chk(UIFL_OFS_IID, 8'hC1);
    endtask : t_prio
    // all word lengths against all parity modes, long stop
    task automatic t_frames();
        logic [7:0] f;
        logic [7:0] d;
        logic [7:0] m;
        logic p;
        for (int wl = 0; wl < 4; wl++) begin
            for (int ps = 0; ps < 5; ps++) begin
                f = {2'b00, ps[1:0], 1'(ps < 4), 1'b1, wl[1:0]};
                d = 8'hB4 ^ f;
                m = 8'hFF >> (3 - wl);
                m_bits = 4'(5 + wl);
                m_par = f[3];
                wr_reg(UIFL_OFS_LFC, f);
                wr_reg(UIFL_OFS_TXD, d);
                wait_rx(got);
                chk(rx_data, d & m);
                p = ps[1] ? ~ps[0] : (^(d & m) ^ ~ps[0]);
                if (ps < 4) chk({7'h00, rx_par}, {7'h00, p});
                chk({7'h00, rx_stop}, 8'h01);
            end
        end
        repeat (12) @(negedge clk);
        rd_chk(UIFL_OFS_IID, 8'hC2);
        rd_chk(UIFL_OFS_IID, 8'hC1);
    endtask : t_frames
    // one word in flight plus sixteen queued, then one refused;
    // short stop here, so back-to-back frames are 11 bits plus one idle
    task automatic t_fill();
        int t0;
        t0 = 0;
        m_bits = 4'h8;
        m_par = 1'b1;
        wr_reg(UIFL_OFS_LFC, 8'h0B);
        for (int i = 1; i < 18; i++) wr_reg(UIFL_OFS_TXD, 8'(i));
        chk({7'h00, wr_ready}, 8'h00);
        wr_reg(UIFL_OFS_TXD, 8'hEE);
        for (int i = 1; i < 18; i++) begin
            wait_rx(got);
            chk(rx_data, 8'(i));
            if (i > 1) chk(8'(cyc - t0), 8'h2D);
            t0 = cyc;
        end
        wait_rx(got);
        chk({7'h00, got}, 8'h00);
    endtask : t_fill
    // data writes are dropped while divisor access is selected
    task automatic t_div();
        wr_reg(UIFL_OFS_LFC, 8'h83);
        wr_reg(UIFL_OFS_TXD, 8'h5A);
        rd_chk(UIFL_OFS_LFC, 8'h83);
        wr_reg(UIFL_OFS_LFC, 8'h03);
        wait_rx(got);
        chk({7'h00, got}, 8'h00);
    endtask : t_div
    task automatic t_break();
        wr_reg(UIFL_OFS_LFC, 8'h43);
        repeat (4) @(negedge clk);
        chk({7'h00, tx}, 8'h00);
        repeat (60) @(negedge clk);
        chk({7'h00, tx}, 8'h00);
        wr_reg(UIFL_OFS_LFC, 8'h03);
        repeat (2) @(negedge clk);
        chk({7'h00, tx}, 8'h01);
    endtask : t_break
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_enh_off();
        t_prio();
        t_frames();
        t_fill();
        t_div();
        t_break();
        report_and_stop();
    end
endmodule : tb_uifl_top
